// ### wcrc_device_end.sv
`default_nettype none

`include "wcrc_consts.svh"

// Contract
// - Checksum over raw lanes, before inversion undo
// - Undo byte inversion before storing data
// - Masking plus checksum: bad burst is dropped
// - Controller avoids register/per-device ops meanwhile
// - Generator polynomial x^8 + x^2 + x + 1
// - 72 inputs, bit 71 first, zero start
// - Each checksum bit is XOR of subset
// - Catch single, double, odd, column errors
// - Fixed eight-beat order, low column bits zero
// - Four-lane width: checksum split over beats 8,9
// - Eight-lane: beat 8 checksum, beat 9 ones
// - Sixteen-lane: two independent byte-half checksums
// - Chopped burst: column bit 2 picks half
// - Mismatch drives the alert output
// - Unused mask/inversion lane is driven ones
// - Chopped high half feeds tree inputs 3:0

// Device end: receives write frames, checks them, hands data to the array
module wcrc_device_end
  import wcrc_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_crc_en,
  input  wire logic                    i_mask_en,
  input  wire logic                    i_inv_en,
  input  wire width_t                  i_width,
  output logic                         o_wr_valid,
  output logic [`SLOT_BITS-1:0]        o_wr_data,
  output logic [`SLOT_BYTES-1:0]       o_wr_byte_en,
  output logic                         o_crc_err,
  output logic [2*`CRC_WIDTH-1:0]      o_computed_checksum,
  wcrc_link_if.dev                     link
);

  // ------------------------------------------------------------------
  // States
  // ------------------------------------------------------------------
  // Sequence idle -> receive -> check -> idle; one bit changes per step except check -> idle
  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_RECV  = 2'b01,
    D_CHECK = 2'b11
  } dstate_t;

  dstate_t              state_q;
  logic [3:0]           cnt_q;
  frame_t               frame_q;
  logic                 chop_q;
  logic                 a2_q;
  logic [3:0]           alert_cnt_q;

  // ------------------------------------------------------------------
  // Checksum compare
  // ------------------------------------------------------------------
  // The tree sees the frame exactly as it crossed the lanes, inversion
  // flags and all, so the controller can build it without undoing anything
  wire  [3:0]              last_w    = i_crc_en ? `LAST_BEAT_CRC : `LAST_BEAT_PLAIN;
  wire  [`TREE_BITS-1:0]   tree_lo_w = tree_in(frame_q, i_width, 1'b0);
  wire  [`TREE_BITS-1:0]   tree_hi_w = tree_in(frame_q, i_width, 1'b1);
  wire  [`CRC_WIDTH-1:0]   calc_lo_w = crc8_72(tree_lo_w);
  wire  [`CRC_WIDTH-1:0]   calc_hi_w = crc8_72(tree_hi_w);
  wire  [`CRC_WIDTH-1:0]   recv_lo_w = rx_crc(frame_q, i_width, 1'b0);
  wire  [`CRC_WIDTH-1:0]   recv_hi_w = rx_crc(frame_q, i_width, 1'b1);
  // Whole-byte compare: any flipped bit that changes the remainder fails
  wire                     bad_lo_w  = (calc_lo_w != recv_lo_w);
  wire                     bad_hi_w  = (i_width == WIDTH_X16) && (calc_hi_w != recv_hi_w);
  wire                     crc_bad_w = i_crc_en && (bad_lo_w || bad_hi_w);
  // Without masking the array takes the burst anyway; the controller
  // must rewrite bad data itself in that mode
  wire                     drop_w    = crc_bad_w && i_mask_en;

  // ------------------------------------------------------------------
  // Data recovery
  // ------------------------------------------------------------------
  logic [`SLOT_BITS-1:0]   data_d;
  logic [`SLOT_BYTES-1:0]  ben_d;

  // Slot placement, inversion undo and mask decode per byte
  always_comb
  begin
    logic [7:0] byt;
    logic       lane;
    logic       inv;
    logic       masked;
    int         s;
    byt    = 8'h00;
    lane   = 1'b1;
    inv    = 1'b0;
    masked = 1'b0;
    s      = 0;
    data_d = '0;
    ben_d  = '0;
    for (int k = 0; k < `DATA_BEATS; k++)
    begin
      // Chopped bursts carry only beats 0..3; column bit 2 says which half
      if (!(chop_q && k >= `CHOP_BEATS))
      begin
        s = (chop_q && a2_q) ? k + `CHOP_BEATS : k;
        for (int b = 0; b < 2; b++)
        begin
          byt    = frame_q[k][8*b +: 8];
          lane   = frame_q[k][`LANE_MASK_LO+b];
          // Masking wins if both are set; the pair is not a legal mode
          masked = i_mask_en && !lane;
          inv    = i_inv_en && !i_mask_en && !lane;
          data_d[s*16+8*b +: 8] = inv ? ~byt : byt;
          ben_d[s*2+b]          = !masked && (b == 0 || i_width == WIDTH_X16);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Frame receiver
  // ------------------------------------------------------------------
  // A command during receive or check is ignored; spacing relies on requests waiting for the controller's o_ready
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= D_IDLE;
      cnt_q   <= 4'h0;
      chop_q  <= 1'b0;
      a2_q    <= 1'b0;
      frame_q <= '1;
    end
    else
    begin
      unique case (state_q)
        D_IDLE:
        begin
          if (link.wr_cmd)
          begin
            state_q <= D_RECV;
            cnt_q   <= 4'h0;
            chop_q  <= link.cmd_chop;
            a2_q    <= link.cmd_chop & link.cmd_a2;
            frame_q <= '1;
          end
        end
        D_RECV:
        begin
          if (link.beat_valid)
          begin
            frame_q[cnt_q] <= link.beat;
            cnt_q          <= cnt_q + 4'h1;
            if (cnt_q == last_w)
              state_q <= D_CHECK;
          end
        end
        D_CHECK:
        begin
          state_q <= D_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Array hand-off
  // ------------------------------------------------------------------
  // All writes leave after the check; one cycle of latency buys a single
  // path whether or not masking is on
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_wr_valid          <= 1'b0;
      o_wr_data           <= '0;
      o_wr_byte_en        <= '0;
      o_crc_err           <= 1'b0;
      o_computed_checksum <= '0;
    end
    else
    begin
      o_wr_valid <= 1'b0;
      o_crc_err  <= 1'b0;
      if (state_q == D_CHECK)
      begin
        o_wr_valid          <= !drop_w;
        o_wr_data           <= data_d;
        o_wr_byte_en        <= ben_d;
        o_crc_err           <= crc_bad_w;
        o_computed_checksum <= {calc_hi_w, calc_lo_w};
      end
    end
  end

  // ------------------------------------------------------------------
  // Alert pin
  // ------------------------------------------------------------------
  // Fixed-width low pulse; a new error restarts it
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      alert_cnt_q  <= 4'h0;
      link.alert_n <= 1'b1;
    end
    else if (state_q == D_CHECK && crc_bad_w)
    begin
      alert_cnt_q  <= `ALERT_PULSE_CYC - 4'h1;
      link.alert_n <= 1'b0;
    end
    else if (alert_cnt_q != 4'h0)
    begin
      alert_cnt_q  <= alert_cnt_q - 4'h1;
      link.alert_n <= 1'b0;
    end
    else
    begin
      link.alert_n <= 1'b1;
    end
  end

endmodule : wcrc_device_end

`default_nettype wire

// ### wcrc_consts.svh
`ifndef WCRC_CONSTS_SVH
`define WCRC_CONSTS_SVH

// ------------------------------------------------------------------
// Checksum tree
// ------------------------------------------------------------------
`define CRC_WIDTH        8
`define CRC_POLY         8'h07
`define CRC_INIT         8'h00
`define TREE_BITS        72

// ------------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------------
`define DQ_LANES         16
`define BEAT_BITS        18
`define LANE_MASK_LO     16
`define LANE_MASK_HI     17
`define MASK_TREE_BASE   64
`define FRAME_BEATS      10
`define DATA_BEATS       8
`define CHOP_BEATS       4
`define CRC_BEAT_LO      8
`define CRC_BEAT_HI      9
`define LAST_BEAT_CRC    4'h9
`define LAST_BEAT_PLAIN  4'h7
`define SLOT_BITS        128
`define SLOT_BYTES       16

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define ALERT_PULSE_CYC  4'h6

`endif

// ### wcrc_pkg.sv
`default_nettype none

package wcrc_pkg;
  `include "wcrc_consts.svh"

  // Device data width
  typedef enum logic [1:0] {
    WIDTH_X4  = 2'h0,
    WIDTH_X8  = 2'h1,
    WIDTH_X16 = 2'h2
  } width_t;

  typedef logic [`BEAT_BITS-1:0]                beat_t;
  typedef beat_t [`FRAME_BEATS-1:0]             frame_t;

  // Serial division, bit 71 first, zero start remainder
  function automatic logic [`CRC_WIDTH-1:0] crc8_72(input logic [`TREE_BITS-1:0] d);
    logic [`CRC_WIDTH-1:0] c;
    logic                  fb;
    c  = `CRC_INIT;
    fb = 1'b0;
    for (int i = `TREE_BITS - 1; i >= 0; i--)
    begin
      fb = c[`CRC_WIDTH-1] ^ d[i];
      c  = {c[`CRC_WIDTH-2:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8_72

  // Tree input from the raw beats of one byte half; absent lanes are ones
  function automatic logic [`TREE_BITS-1:0] tree_in(input frame_t f, input width_t w,
                                                   input logic up);
    logic [`TREE_BITS-1:0] d;
    d = '1;
    for (int k = 0; k < `DATA_BEATS; k++)
    begin
      for (int n = 0; n < 8; n++)
        d[8*n+k] = (w == WIDTH_X4 && n > 3) ? 1'b1 : f[k][n + (up ? 8 : 0)];
      d[`MASK_TREE_BASE+k] = (w == WIDTH_X4) ? 1'b1
                           : f[k][up ? `LANE_MASK_HI : `LANE_MASK_LO];
    end
    return d;
  endfunction : tree_in

  // Checksum as carried in beats 8 and 9
  function automatic logic [`CRC_WIDTH-1:0] rx_crc(input frame_t f, input width_t w,
                                                  input logic up);
    logic [`CRC_WIDTH-1:0] c;
    if (w == WIDTH_X4)
      c = {f[`CRC_BEAT_HI][3:0], f[`CRC_BEAT_LO][3:0]};
    else
      c = up ? f[`CRC_BEAT_LO][15:8] : f[`CRC_BEAT_LO][7:0];
    return c;
  endfunction : rx_crc

endpackage : wcrc_pkg

`default_nettype wire

// ### wcrc_link_if.sv
`default_nettype none

// Write link between controller and memory device, one clock
interface wcrc_link_if;
  import wcrc_pkg::*;

  logic  wr_cmd;      // Write command pulse
  logic  cmd_chop;    // Four-beat chopped burst
  logic  cmd_a2;      // Column bit 2, picks the half a chopped burst carries
  logic  beat_valid;  // One transfer on the lanes
  beat_t beat;        // Data lanes plus mask/inversion lanes
  logic  alert_n;     // Checksum error, active low

  modport ctrl (output wr_cmd, output cmd_chop, output cmd_a2,
                output beat_valid, output beat, input alert_n);
  modport dev  (input wr_cmd, input cmd_chop, input cmd_a2,
                input beat_valid, input beat, output alert_n);
endinterface : wcrc_link_if

`default_nettype wire

// ### wcrc_controller_end.sv
`default_nettype none

`include "wcrc_consts.svh"

// Controller end: builds the write frame with checksum and drives it out
module wcrc_controller_end
  import wcrc_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_crc_en,
  input  wire logic                    i_mask_en,
  input  wire logic                    i_inv_en,
  input  wire width_t                  i_width,
  input  wire logic                    i_wr_req,
  input  wire logic                    i_chop,
  input  wire logic                    i_a2,
  input  wire logic [`SLOT_BITS-1:0]   i_wr_data,
  input  wire logic [`SLOT_BYTES-1:0]  i_wr_mask_n,
  output logic                         o_ready,
  output logic                         o_alert_seen,
  wcrc_link_if.ctrl                    link
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    C_IDLE = 1'b0,
    C_SEND = 1'b1
  } cstate_t;

  cstate_t     state_q;
  logic [3:0]  idx_q;
  frame_t      frame_q;
  frame_t      frame_d;
  logic        alert_n_q;
  wire  [3:0]  last_w = i_crc_en ? `LAST_BEAT_CRC : `LAST_BEAT_PLAIN;
  wire         take_w = (state_q == C_IDLE) && i_wr_req;

  // ------------------------------------------------------------------
  // Frame build
  // ------------------------------------------------------------------
  // Everything in one cycle; the tree is shallow enough at this rate
  always_comb
  begin
    logic [7:0]            byt;
    logic                  inv;
    int                    s;
    logic [`CRC_WIDTH-1:0] lo;
    logic [`CRC_WIDTH-1:0] hi;
    byt     = 8'h00;
    inv     = 1'b0;
    s       = 0;
    frame_d = '1;
    for (int k = 0; k < `DATA_BEATS; k++)
    begin
      // Chopped bursts send ones in beats 4..7
      if (!(i_chop && k >= `CHOP_BEATS))
      begin
        s = (i_chop && i_a2) ? k + `CHOP_BEATS : k;
        for (int b = 0; b < 2; b++)
        begin
          byt = i_wr_data[s*16+8*b +: 8];
          inv = 1'b0;
          if (i_mask_en)
            frame_d[k][`LANE_MASK_LO+b] = i_wr_mask_n[s*2+b];
          else if (i_inv_en)
          begin
            inv = ($countones(byt) < 4);
            frame_d[k][`LANE_MASK_LO+b] = ~inv;
          end
          else
            frame_d[k][`LANE_MASK_LO+b] = 1'b1;
          frame_d[k][8*b +: 8] = inv ? ~byt : byt;
        end
      end
      // Lanes the device width lacks stay at ones
      if (i_width == WIDTH_X4)
        frame_d[k][`BEAT_BITS-1:4] = '1;
      else if (i_width == WIDTH_X8)
      begin
        frame_d[k][15:8]          = 8'hFF;
        frame_d[k][`LANE_MASK_HI] = 1'b1;
      end
    end
    lo = crc8_72(tree_in(frame_d, i_width, 1'b0));
    hi = crc8_72(tree_in(frame_d, i_width, 1'b1));
    if (i_width == WIDTH_X4)
    begin
      frame_d[`CRC_BEAT_LO][3:0] = lo[3:0];
      frame_d[`CRC_BEAT_HI][3:0] = lo[7:4];
    end
    else
      frame_d[`CRC_BEAT_LO][7:0] = lo;
    if (i_width == WIDTH_X16)
      frame_d[`CRC_BEAT_LO][15:8] = hi;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Only plain writes exist here, so no register or per-device access
  // can collide with checksum mode
  always_ff @(posedge i_clk)
  begin
    link.wr_cmd <= 1'b0;
    if (i_srst)
    begin
      state_q         <= C_IDLE;
      idx_q           <= 4'h0;
      frame_q         <= '1;
      o_ready         <= 1'b0;
      link.cmd_chop   <= 1'b0;
      link.cmd_a2     <= 1'b0;
      link.beat_valid <= 1'b0;
      link.beat       <= '1;
    end
    else if (take_w)
    begin
      state_q       <= C_SEND;
      idx_q         <= 4'h0;
      frame_q       <= frame_d;
      o_ready       <= 1'b0;
      link.wr_cmd   <= 1'b1;
      link.cmd_chop <= i_chop;
      link.cmd_a2   <= i_chop & i_a2;
    end
    else if (state_q == C_SEND)
    begin
      link.beat_valid <= 1'b1;
      link.beat       <= frame_q[idx_q];
      idx_q           <= idx_q + 4'h1;
      if (idx_q == last_w)
        state_q <= C_IDLE;
    end
    else
    begin
      link.beat_valid <= 1'b0;
      link.beat       <= '1;
      o_ready         <= 1'b1;
    end
  end

  // Alert falling edge; the link is synchronous so no synchroniser
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      alert_n_q    <= 1'b1;
      o_alert_seen <= 1'b0;
    end
    else
    begin
      alert_n_q    <= link.alert_n;
      o_alert_seen <= alert_n_q & ~link.alert_n;
    end
  end

endmodule : wcrc_controller_end

`default_nettype wire

// ### wcrc_props.sv
`default_nettype none

// ------------------------------------------------------------------
// Link checker between controller end and device end
// ------------------------------------------------------------------
module wcrc_props
  import wcrc_pkg::*;
(
  input wire logic  i_clk,
  input wire logic  i_srst,
  input wire logic  wr_cmd,
  input wire logic  cmd_chop,
  input wire logic  cmd_a2,
  input wire logic  beat_valid,
  input wire beat_t beat,
  input wire logic  alert_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // One clock domain, so clocking and reset are stated once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_cmd_single_pulse: assert property (wr_cmd |=> !wr_cmd)
    else $error("write command longer than one cycle");
  a_cmd_not_in_burst: assert property (beat_valid |-> !wr_cmd)
    else $error("write command during a burst");
  a_eight_beats_follow: assert property (wr_cmd |=> beat_valid [*8])
    else $error("burst shorter than eight beats");
  a_a2_only_chop: assert property (wr_cmd && !cmd_chop |-> !cmd_a2)
    else $error("column bit 2 set on a full burst");
  a_chop_tail_ones: assert property (wr_cmd && cmd_chop |-> ##5 (beat == '1) [*4])
    else $error("chopped burst tail beats not all ones");
  a_idle_lanes_ones: assert property (!beat_valid |-> beat == '1)
    else $error("lanes not released to ones between beats");
  // Mask lane carries ones in both checksum beats; beat 9 upper lanes ones
  a_crc_beats_fill: assert property (
    wr_cmd ##9 beat_valid |-> beat[17:16] == 2'h3 ##1 (beat[17:8] == 10'h3FF))
    else $error("checksum beats carry wrong filler");
  a_alert_six_low: assert property ($fell(alert_n) |-> (!alert_n) [*6] ##1 alert_n)
    else $error("alert pulse not six cycles");
  a_alert_after_last: assert property ($fell(alert_n) |->
    !beat_valid && ($past(beat_valid, 2) || $past(beat_valid, 3)))
    else $error("alert not tied to the end of a burst");

  // Main traffic kinds seen on the link
  c_chop_high: cover property (wr_cmd && cmd_chop && cmd_a2);
  c_chop_low: cover property (wr_cmd && cmd_chop && !cmd_a2);
  c_full_frame: cover property (wr_cmd ##10 beat_valid);
endmodule : wcrc_props

`default_nettype wire

// ### tb_write_data_crc_checker.sv
`default_nettype none

// ------------------------------------------------------------------
// Both ends joined, plus a second device fed by a faulty driver
// ------------------------------------------------------------------
module tb_write_data_crc_checker
  import wcrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [127:0] pat = 128'h5A3C_96E1_0F78_C3A5_1E2D_4B87_F00F_6699;
  localparam logic [127:0] inv_pat = 128'h0180_FE7F_0301_C0FF_1000_EF08_2004_77F1;

  logic         i_clk = 1'h0;
  logic         i_srst = 1'h1;
  logic         crc_en = 1'h1, mask_en = 1'h0, inv_en = 1'h0;
  width_t       width = WIDTH_X8;
  logic         wr_req = 1'h0, chop = 1'h0, a2 = 1'h0;
  logic [127:0] wr_data = '0, d1;
  logic         ready, alert_seen, v1, e1, v2, e2, got_v, got_e, got_a;
  logic         skew = 1'h0;
  logic [15:0]  wmask = 16'hFFFF;
  logic [15:0]  be1, ck1;
  int           err_total = 0, samples_checked = 0, cycles = 0, alerts;
  wcrc_link_if  link_a ();
  wcrc_link_if  link_b ();

  wcrc_controller_end wcrc_controller_end_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_crc_en(crc_en), .i_mask_en(mask_en), .i_inv_en(inv_en), .i_width(width),
    .i_wr_req(wr_req), .i_chop(chop), .i_a2(a2), .i_wr_data(wr_data),
    .i_wr_mask_n(wmask), .o_ready(ready), .o_alert_seen(alert_seen), .link(link_a.ctrl));
  // Skew sets the first device to sixteen lanes so its upper tree sees a bad checksum
  wcrc_device_end wcrc_device_end_i (.i_clk(i_clk), .i_srst(i_srst), .i_crc_en(crc_en),
    .i_mask_en(mask_en), .i_inv_en(inv_en), .i_width(skew ? WIDTH_X16 : width), .o_wr_valid(v1),
    .o_wr_data(d1), .o_wr_byte_en(be1), .o_crc_err(e1), .o_computed_checksum(ck1),
    .link(link_a.dev));
  // Second device sees frames from the bench driver, one good and others corrupted on purpose
  wcrc_device_end wcrc_device_end_i2 (.i_clk(i_clk), .i_srst(i_srst), .i_crc_en(crc_en),
    .i_mask_en(mask_en), .i_inv_en(inv_en), .i_width(width), .o_wr_valid(v2),
    .o_wr_data(), .o_wr_byte_en(), .o_crc_err(e2), .o_computed_checksum(),
    .link(link_b.dev));
  wcrc_props wcrc_props_i (.i_clk(i_clk), .i_srst(i_srst), .wr_cmd(link_a.wr_cmd),
    .cmd_chop(link_a.cmd_chop), .cmd_a2(link_a.cmd_a2), .beat_valid(link_a.beat_valid),
    .beat(link_a.beat), .alert_n(link_a.alert_n));

  // Clock and hang limit; the whole run needs well under 1000 cycles
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Serial remainder, own copy so the bench does not share the design's
  function automatic logic [7:0] crc_of(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc_of

  // Raw tree input as sent: inverted bytes and low lane when few ones
  function automatic logic [71:0] tree(input logic [127:0] d, input logic up, input int s0,
                                       input int n);
    logic [71:0] t;
    logic [7:0]  b;
    t = '1;
    for (int k = 0; k < n; k++)
    begin
      b = d[(s0 + k) * 16 + (up ? 8 : 0) +: 8];
      if (inv_en && $countones(b) < 4)
      begin
        b = ~b;
        t[64 + k] = 1'h0;
      end
      for (int j = 0; j < 8; j++)
        t[8 * j + k] = b[j];
    end
    return t;
  endfunction : tree

  task automatic ctrl_write(input logic [127:0] d, input logic ch, input logic hi);
    int n;
    n = 0;
    @(negedge i_clk);
    while (ready !== 1'h1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    wr_req = 1'h1;
    chop = ch;
    a2 = hi;
    wr_data = d;
    @(negedge i_clk);
    wr_req = 1'h0;
    got_v = 1'h0;
    got_e = 1'h0;
    got_a = 1'h0;
    repeat (20)
    begin
      @(negedge i_clk);
      got_v |= v1;
      got_e |= e1;
      got_a |= alert_seen;
    end
  endtask : ctrl_write

  // Eight-lane frame with a correct checksum in beat 8
  function automatic frame_t mk_frame(input logic [127:0] d);
    frame_t f;
    f = '1;
    for (int k = 0; k < 8; k++)
      f[k][7:0] = d[k * 16 +: 8];
    f[8][7:0] = crc_of(tree(d, 1'h0, 0, 8));
    return f;
  endfunction : mk_frame

  task automatic drive_b(input frame_t f);
    @(negedge i_clk);
    link_b.wr_cmd = 1'h1;
    @(negedge i_clk);
    link_b.wr_cmd = 1'h0;
    for (int k = 0; k < 10; k++)
    begin
      link_b.beat_valid = 1'h1;
      link_b.beat = f[k];
      @(negedge i_clk);
    end
    link_b.beat_valid = 1'h0;
    link_b.beat = '1;
    got_v = 1'h0;
    got_e = 1'h0;
    alerts = 0;
    repeat (12)
    begin
      @(negedge i_clk);
      got_v |= v2;
      got_e |= e2;
      if (link_b.alert_n === 1'h0)
        alerts++;
    end
  endtask : drive_b

  task automatic t_widths();
    logic [127:0] d;
    for (int w = 0; w < 3; w++)
    begin
      width = width_t'(w);
      d = (w == 0) ? (pat | {16{8'hF0}}) : pat;
      ctrl_write(d, 1'h0, 1'h0);
      chk("commit", 1'h1, got_v);
      chk("crc_err", 1'h0, got_e);
      chk("alert", 1'h0, got_a);
      chk("crc_lo", crc_of(tree(d, 1'h0, 0, 8)), ck1[7:0]);
      if (w == 2)
        chk("crc_hi", crc_of(tree(d, 1'h1, 0, 8)), ck1[15:8]);
    end
    $display("test widths done");
  endtask : t_widths

  task automatic t_inversion();
    width = WIDTH_X16;
    inv_en = 1'h1;
    ctrl_write(inv_pat, 1'h0, 1'h0);
    chk("data", inv_pat, d1);
    chk("byte_en", 16'hFFFF, be1);
    chk("crc_lo", crc_of(tree(inv_pat, 1'h0, 0, 8)), ck1[7:0]);
    chk("crc_hi", crc_of(tree(inv_pat, 1'h1, 0, 8)), ck1[15:8]);
    inv_en = 1'h0;
    $display("test inversion done");
  endtask : t_inversion

  task automatic t_chop();
    width = WIDTH_X8;
    for (int h = 0; h < 2; h++)
    begin
      ctrl_write(pat, 1'h1, h[0]);
      chk("chop_crc", crc_of(tree(pat, 1'h0, 4 * h, 4)), ck1[7:0]);
      chk("chop_be", h ? 16'h5500 : 16'h0055, be1);
    end
    $display("test chop done");
  endtask : t_chop

  // Masked commit, plain bursts, and a lane mismatch that must raise the alert
  task automatic t_modes();
    width = WIDTH_X16;
    mask_en = 1'h1;
    wmask = 16'h5AA5;
    ctrl_write(pat, 1'h0, 1'h0);
    chk("mask_be", 16'h5AA5, be1);
    chk("mask_commit", 1'h1, got_v);
    mask_en = 1'h0;
    wmask = 16'hFFFF;
    crc_en = 1'h0;
    ctrl_write(pat, 1'h0, 1'h0);
    chk("plain_data", pat, d1);
    chk("plain_err", 1'h0, got_e);
    crc_en = 1'h1;
    // Eight-lane sender, sixteen-lane receiver: upper tree sees all ones
    width = WIDTH_X8;
    skew = 1'h1;
    ctrl_write(pat, 1'h0, 1'h0);
    chk("skew_err", crc_of('1) != 8'hFF, got_e);
    chk("skew_alert", crc_of('1) != 8'hFF, got_a);
    chk("skew_hi", crc_of('1), ck1[15:8]);
    chk("skew_commit", 1'h1, got_v);
    skew = 1'h0;
    $display("test modes done");
  endtask : t_modes

  // Corrupted frames: masked mode drops them, plain mode still commits
  task automatic t_fault();
    frame_t f;
    f = mk_frame(pat);
    mask_en = 1'h1;
    drive_b(f);
    chk("good_commit", 1'h1, got_v);
    chk("good_err", 1'h0, got_e);
    f[3][5] = ~f[3][5];
    drive_b(f);
    chk("bad_commit", 1'h0, got_v);
    chk("bad_err", 1'h1, got_e);
    chk("alert_len", 6, alerts);
    f[3][5] = ~f[3][5];
    f[2][1] = ~f[2][1];
    f[2][2] = ~f[2][2];
    mask_en = 1'h0;
    drive_b(f);
    chk("nomask_commit", 1'h1, got_v);
    chk("column_err", 1'h1, got_e);
    $display("test fault done");
  endtask : t_fault

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Faulty driver idles at ones; reset held six cycles
  initial
  begin
    link_b.wr_cmd = 1'h0;
    link_b.cmd_chop = 1'h0;
    link_b.cmd_a2 = 1'h0;
    link_b.beat_valid = 1'h0;
    link_b.beat = '1;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'h0;
    t_widths();
    t_inversion();
    t_chop();
    t_modes();
    t_fault();
    end_sim();
  end
endmodule : tb_write_data_crc_checker

`default_nettype wire
